// ==== inc/sdv_pkg.sv ====
// Package for the sequential divider: widths, counts, state encoding.
// Assumes nothing of its surroundings.
`default_nettype none
package sdv_pkg;
  localparam int NUMER_WIDTH = 64;
  localparam int DENOM_WIDTH = 16;
  localparam int STEP_WIDTH = 7;
  localparam logic [STEP_WIDTH-1:0] LAST_STEP = 7'h3f;
  localparam logic [STEP_WIDTH-1:0] STEP_RESET = 7'h00;
  localparam logic [NUMER_WIDTH-1:0] QUOT_RESET = 64'h0;
  localparam logic [DENOM_WIDTH-1:0] REM_RESET = 16'h0;
  localparam logic DONE_RESET = 1'b1;
  typedef enum logic [1:0] {
    SDV_IDLE = 2'b00,
    SDV_LOAD = 2'b01,
    SDV_RUN = 2'b11
  } sdv_state_t;
endpackage : sdv_pkg
`default_nettype wire

// ==== logic/sdv_step.sv ====
// One restoring-division step: shift in one dividend bit, try subtract.
// Assumes operands are unsigned; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module sdv_step (
  input wire logic [sdv_pkg::DENOM_WIDTH-1:0] partRem,
  input wire logic nextBit,
  input wire logic [sdv_pkg::DENOM_WIDTH-1:0] divisor,
  output logic [sdv_pkg::DENOM_WIDTH-1:0] newRem,
  output logic quotBit
);
  logic [sdv_pkg::DENOM_WIDTH:0] trial;
  logic [sdv_pkg::DENOM_WIDTH:0] diff;
  always_comb begin
    trial = {partRem, nextBit};
    diff = trial - {1'b0, divisor};
    quotBit = (trial >= {1'b0, divisor});
    newRem = quotBit ? diff[sdv_pkg::DENOM_WIDTH-1:0] : trial[sdv_pkg::DENOM_WIDTH-1:0];
  end
endmodule // sdv_step
`default_nettype wire

// ==== logic/sdv_divider.sv ====
// Sequential unsigned divider, one quotient bit per clock.
// Assumes start, numer and denom come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Quotient width equals dividend width parameter
// - Remainder width equals divisor width parameter
// - All steps advance on single clock
// - Reset clears results, holds done high
// - Capture operands every clock start high
// - Division begins when start falls
// - Input changes ignored after capture
// - Quotient valid only while done high
// - Remainder valid only while done high
// - Done rises when results final
module sdv_divider (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [sdv_pkg::NUMER_WIDTH-1:0] numer,
  input wire logic [sdv_pkg::DENOM_WIDTH-1:0] denom,
  output logic [sdv_pkg::NUMER_WIDTH-1:0] quotient,
  output logic [sdv_pkg::DENOM_WIDTH-1:0] remain,
  output logic done
);
  sdv_pkg::sdv_state_t state_reg;
  logic [sdv_pkg::NUMER_WIDTH-1:0] numer_reg;
  logic [sdv_pkg::DENOM_WIDTH-1:0] denom_reg;
  logic [sdv_pkg::NUMER_WIDTH-1:0] work_reg;
  logic [sdv_pkg::DENOM_WIDTH-1:0] rem_reg;
  logic [sdv_pkg::STEP_WIDTH-1:0] step_reg;
  logic [sdv_pkg::DENOM_WIDTH-1:0] rem_next;
  logic quotBit;
  logic [sdv_pkg::NUMER_WIDTH-1:0] work_next;

  sdv_step u_step (
    .partRem(rem_reg),
    .nextBit(work_reg[sdv_pkg::NUMER_WIDTH-1]),
    .divisor(denom_reg),
    .newRem(rem_next),
    .quotBit(quotBit)
  );

  // Dividend shifts out the top while quotient bits fill the bottom
  assign work_next = {work_reg[sdv_pkg::NUMER_WIDTH-2:0], quotBit};

  // Operand capture while start is high
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      numer_reg <= sdv_pkg::QUOT_RESET;
      denom_reg <= sdv_pkg::REM_RESET;
    end else if (start) begin
      numer_reg <= numer;
      denom_reg <= denom;
    end
  end

  // Sequencing
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= sdv_pkg::SDV_IDLE;
      step_reg <= sdv_pkg::STEP_RESET;
    end else begin
      unique case (state_reg)
        sdv_pkg::SDV_IDLE: begin
          if (start) begin
            state_reg <= sdv_pkg::SDV_LOAD;
          end
        end
        sdv_pkg::SDV_LOAD: begin
          if (!start) begin
            state_reg <= sdv_pkg::SDV_RUN;
            step_reg <= sdv_pkg::STEP_RESET;
          end
        end
        sdv_pkg::SDV_RUN: begin
          if (start) begin
            state_reg <= sdv_pkg::SDV_LOAD;
          end else if (step_reg == sdv_pkg::LAST_STEP) begin
            state_reg <= sdv_pkg::SDV_IDLE;
          end else begin
            step_reg <= step_reg + 7'h01;
          end
        end
        default: begin
          state_reg <= sdv_pkg::SDV_IDLE;
        end
      endcase
    end
  end

  // Datapath
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      work_reg <= sdv_pkg::QUOT_RESET;
      rem_reg <= sdv_pkg::REM_RESET;
    end else if (state_reg == sdv_pkg::SDV_LOAD && !start) begin
      work_reg <= numer_reg;
      rem_reg <= sdv_pkg::REM_RESET;
    end else if (state_reg == sdv_pkg::SDV_RUN && !start) begin
      work_reg <= work_next;
      rem_reg <= rem_next;
    end
  end

  // Results and completion flag
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      quotient <= sdv_pkg::QUOT_RESET;
      remain <= sdv_pkg::REM_RESET;
      done <= sdv_pkg::DONE_RESET;
    end else if (start) begin
      done <= 1'b0;
    end else if (state_reg == sdv_pkg::SDV_RUN && step_reg == sdv_pkg::LAST_STEP) begin
      quotient <= work_next;
      remain <= rem_next;
      done <= 1'b1;
    end
  end
endmodule // sdv_divider
`default_nettype wire

// ==== verif/sdv_divider_asserts.sv ====
// Port checker for the divider.
// Assumes binding to sdv_divider, one clock.
`timescale 1ns/1ps
`default_nettype none
module sdv_divider_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [sdv_pkg::NUMER_WIDTH-1:0] quotient,
  input wire logic [sdv_pkg::DENOM_WIDTH-1:0] remain,
  input wire logic done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_reset_clears: assert property (disable iff (1'b0)
    !rst_b |=> done && quotient == '0 && remain == '0) else $error("reset values wrong");
  a_start_drops: assert property (start |=> !done) else $error("done high after start");
  a_done_time: assert property (start ##1 !start |-> ##64 !done ##1 done)
    else $error("done timing wrong");
  a_done_holds: assert property (done && !start |=> done) else $error("done dropped");
  a_result_stable: assert property (done && !start |=> $stable(quotient) && $stable(remain))
    else $error("results moved");
  a_run_low: assert property ($fell(done) |-> !done[*8]) else $error("done rose early");
  a_quot_width: assert property ($bits(quotient) == sdv_pkg::NUMER_WIDTH) else $error("width");
  a_rem_width: assert property ($bits(remain) == sdv_pkg::DENOM_WIDTH) else $error("width");
  c_finish: cover property ($rose(done));
  c_launch: cover property (start ##1 !start);
  c_release: cover property (disable iff (1'b0) !rst_b ##1 rst_b);
endmodule // sdv_divider_asserts
bind sdv_divider sdv_divider_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .start(start),
  .quotient(quotient), .remain(remain), .done(done));
`default_nettype wire

// ==== verif/sdv_user_model.sv ====
// User logic model: one start pulse per request, then scrambles operands.
// Assumes go is set by the bench at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sdv_user_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic [63:0] a,
  input wire logic [15:0] b,
  input wire logic done,
  output logic start,
  output logic [63:0] numer,
  output logic [15:0] denom
);
  initial begin
    start = 1'b0;
    numer = 64'h0;
    denom = 16'h0;
  end
  always @(negedge mclk) begin
    if (go && done && !start) begin
      start <= 1'b1;
      numer <= a;
      denom <= b;
    end else begin
      start <= 1'b0;
      numer <= ~numer;
      denom <= ~denom;
    end
  end
endmodule // sdv_user_model
`default_nettype wire

// ==== verif/sdv_divider_bench.sv ====
// Self-checking bench for the divider.
// Assumes the checker file and the user model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sdv_divider_bench;
  logic mclk = 1'b0, rst_b = 1'b0, go = 1'b0, start, done;
  logic [63:0] a = 64'h0, numer, quotient;
  logic [15:0] b = 16'h1, denom, remain;
  int fail_count = 0, n_tests = 0;
  initial forever #5 mclk = ~mclk;
  sdv_user_model i_user (.mclk(mclk), .go(go), .a(a), .b(b), .done(done), .start(start),
    .numer(numer), .denom(denom));
  sdv_divider i_dut (.mclk(mclk), .rst_b(rst_b), .start(start), .numer(numer), .denom(denom),
    .quotient(quotient), .remain(remain), .done(done));
  task conclude;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task t_div(input logic [63:0] x, input logic [15:0] y);
    int i;
    @(negedge mclk) {a, b, go} <= {x, y, 1'b1};
    @(negedge mclk) go <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(done, 1'b0);
    for (i = 0; i < 100 && done !== 1'b1; i++) @(negedge mclk);
    if (done !== 1'b1) begin
      fail_count++;
      conclude;
    end
    chk(quotient, x / y);
    chk(remain, x % y);
  endtask
  task t_reset;
    @(negedge mclk) rst_b <= 1'b0;
    repeat (2) @(negedge mclk);
    chk(done, 64'h1);
    chk(quotient, 64'h0);
    chk(remain, 64'h0);
    rst_b <= 1'b1;
  endtask
  task t_abort(input logic [63:0] x, input logic [15:0] y);
    @(negedge mclk) {a, b, go} <= {x, y, 1'b1};
    @(negedge mclk) go <= 1'b0;
    repeat (10) @(negedge mclk);
    chk(done, 64'h0);
    t_reset;
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    chk(done, 64'h1);
    chk(quotient, 64'h0);
    chk(remain, 64'h0);
    rst_b <= 1'b1;
    t_div(64'haa, 16'h3);
    t_div(64'hffffffffffffffff, 16'hffff);
    t_div(64'hffffffffffffffff, 16'h1);
    t_div(64'h5, 16'h7);
    t_abort(64'h1234, 16'h9);
    t_div(64'h8000000000000001, 16'h8000);
    conclude;
  end
endmodule // sdv_divider_bench
`default_nettype wire
